// [rtl/fsps_top.sv]
// Flash self-program sequencer: table reads, holding-register table writes, row erase, block program.
// Assumes an APB3 master, a flash macro that answers while its read strobe stands, and AND-style programming.
// Behaviour
// - Table read delivers one byte into the table byte latch.
// - Table access variant may adjust pointer before or after the access.
// - Pointer bit zero picks low or high byte of the flash word.
// - Erase always clears a whole 64-byte row; no word erase.
// - Erase row comes from pointer bits 21:6; bits 5:0 ignored.
// - Launch with erase selected and unlock done starts row erase.
// - Core is stalled for the whole erase, about 2 ms.
// - Long cycle ends only when internal timer expires, then core resumes.
// - Programming always commits a 32-byte block.
// - Thirty-two byte-wide holding registers, loaded by table writes.
// - Table write is short, touches only a holding register, no stall.
// - Core writes control register to launch; device performs stalling block write.
// - Programming duration set by on-chip timer only.
// - Holding registers return to FFh on reset and after programming.
// - FFh holding byte leaves flash byte unchanged; bits only go one to zero.
// - Pointer bits 4:0 pick holding register; bits 21:5 pick programmed block (21:6 row, 5 half).
// - Launch bit settable only; hardware clears it at cycle end.
// - Row-erase select cleared by hardware when erase completes.
// - Write-abort flag set by reset during cycle or improper launch; this design sets it on any reset and when a control write raises permit.
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "fsps_defs.svh"
module fsps_top
   import fsps_pkg::*;
#(parameter logic [16:0] LONG_CYCLES = 17'(`FSPS_LONG_CYC)) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic cpu_stall_o,
   output logic fl_rd_o,
   output logic [20:0] fl_addr_o,
   input wire logic [15:0] fl_rdata_i,
   output logic fl_erase_o,
   output logic fl_prog_o,
   output logic [15:0] fl_row_o,
   output logic fl_half_o,
   output logic [255:0] fl_wdata_o
);
   // ****************************************
   // State
   // ****************************************
   fsps_state_t st_q, st_d;
   fsps_unl_t unl_q, unl_d;
   logic [21:0] ptr_q, ptr_d;
   logic [7:0] latch_q, latch_d;
   logic pgm_q, pgm_d, cfg_q, cfg_d, erase_q, erase_d;
   logic abort_q, abort_d, permit_q, permit_d, launch_q, launch_d;
   logic done_q, done_d, sel_q, sel_d, stall_q, stall_d;
   logic [16:0] timer_q, timer_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   logic fl_rd_q, fl_rd_d, fl_erase_q, fl_erase_d, fl_prog_q, fl_prog_d;
   logic [20:0] fl_addr_q, fl_addr_d;
   logic [15:0] fl_row_q, fl_row_d;
   logic fl_half_q, fl_half_d;
   logic [7:0] hold_q [`FSPS_HOLD_NUM];
   logic [7:0] hold_d [`FSPS_HOLD_NUM];
   logic bus_wr, launch_ok, tw_go, prog_end;
   logic [4:0] tw_idx;
   logic [21:0] ptr_inc, ptr_dec, ptr_use, ptr_post;
   assign bus_wr = psel_i & penable_i & pready_q & pwrite_i;
   // Only the low 21 bits step; bit 21 keeps the space selection
   assign ptr_inc = {ptr_q[21], ptr_q[20:0] + 21'h000001};
   assign ptr_dec = {ptr_q[21], ptr_q[20:0] - 21'h000001};
   // ****************************************
   // Pointer variant decode
   // ****************************************
   always_comb begin
      ptr_use = ptr_q;
      ptr_post = ptr_q;
      case (pwdata_i[1:0])
         `FSPS_VAR_POSTINC: ptr_post = ptr_inc;
         `FSPS_VAR_POSTDEC: ptr_post = ptr_dec;
         `FSPS_VAR_PREINC: begin
            ptr_use = ptr_inc;
            ptr_post = ptr_inc;
         end
         default: ptr_post = ptr_q;
      endcase
   end
   // ****************************************
   // Bus slave, control and sequencer
   // ****************************************
   always_comb begin
      st_d = st_q;
      unl_d = unl_q;
      ptr_d = ptr_q;
      latch_d = latch_q;
      pgm_d = pgm_q;
      cfg_d = cfg_q;
      erase_d = erase_q;
      abort_d = abort_q;
      permit_d = permit_q;
      launch_d = launch_q;
      done_d = done_q;
      sel_d = sel_q;
      timer_d = timer_q;
      prdata_d = prdata_q;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      fl_rd_d = 1'b0;
      fl_addr_d = fl_addr_q;
      fl_erase_d = fl_erase_q;
      fl_prog_d = fl_prog_q;
      fl_row_d = fl_row_q;
      fl_half_d = fl_half_q;
      launch_ok = 1'b0;
      tw_go = 1'b0;
      tw_idx = ptr_use[4:0];
      prog_end = 1'b0;
      // Answers wait while a cycle runs; that wait is the core stall
      if (psel_i && penable_i && !pready_q && st_q == FSPS_ST_IDLE) begin
         pready_d = 1'b1;
         prdata_d = 32'h00000000;
         case (paddr_i)
            `FSPS_OFS_CTRL: prdata_d[7:0] = {pgm_q, cfg_q, 1'b0, erase_q, abort_q, permit_q, launch_q, 1'b0};
            `FSPS_OFS_UNLOCK, `FSPS_OFS_CMD: prdata_d = 32'h00000000;
            `FSPS_OFS_PTR: prdata_d[21:0] = ptr_q;
            `FSPS_OFS_LATCH: prdata_d[7:0] = latch_q;
            `FSPS_OFS_STATUS: begin
               prdata_d[`FSPS_STAT_DONE] = done_q;
               prdata_d[`FSPS_STAT_OPEN] = (unl_q == FSPS_UNL_OPEN);
            end
            default: pslverr_d = 1'b1;
         endcase
      end
      if (bus_wr) begin
         case (paddr_i)
            `FSPS_OFS_CTRL: begin
               pgm_d = pwdata_i[`FSPS_CTRL_PGM];
               cfg_d = pwdata_i[`FSPS_CTRL_CFG];
               erase_d = pwdata_i[`FSPS_CTRL_ERASE];
               permit_d = pwdata_i[`FSPS_CTRL_PERMIT];
               if (pwdata_i[`FSPS_CTRL_PERMIT] && !permit_q) abort_d = 1'b1;
               // Any control write consumes the unlock
               unl_d = FSPS_UNL_NONE;
               if (pwdata_i[`FSPS_CTRL_LAUNCH]) begin
                  if (unl_q == FSPS_UNL_OPEN && pwdata_i[`FSPS_CTRL_PERMIT] && pwdata_i[`FSPS_CTRL_PGM]
                      && !pwdata_i[`FSPS_CTRL_CFG]) begin
                     launch_ok = 1'b1;
                  end else begin
                     abort_d = 1'b1;
                  end
               end
            end
            `FSPS_OFS_UNLOCK: begin
               if (pwdata_i[7:0] == `FSPS_KEY_FIRST) unl_d = FSPS_UNL_GOT1;
               else if (pwdata_i[7:0] == `FSPS_KEY_SECOND && unl_q == FSPS_UNL_GOT1) unl_d = FSPS_UNL_OPEN;
               else unl_d = FSPS_UNL_NONE;
            end
            `FSPS_OFS_PTR: ptr_d = pwdata_i[21:0];
            `FSPS_OFS_LATCH: latch_d = pwdata_i[7:0];
            `FSPS_OFS_CMD: begin
               ptr_d = ptr_post;
               if (pwdata_i[`FSPS_CMD_WRITE]) begin
                  tw_go = 1'b1;
               end else begin
                  st_d = FSPS_ST_RD;
                  fl_rd_d = 1'b1;
                  fl_addr_d = ptr_use[21:1];
                  sel_d = ptr_use[0];
               end
            end
            `FSPS_OFS_STATUS: if (pwdata_i[`FSPS_STAT_DONE]) done_d = 1'b0;
            default: st_d = st_q;
         endcase
      end
      case (st_q)
         FSPS_ST_IDLE: begin
            if (launch_ok) begin
               st_d = FSPS_ST_LONG;
               launch_d = 1'b1;
               timer_d = LONG_CYCLES;
               fl_row_d = ptr_q[21:6];
               fl_half_d = ptr_q[5];
               fl_erase_d = pwdata_i[`FSPS_CTRL_ERASE];
               fl_prog_d = !pwdata_i[`FSPS_CTRL_ERASE];
            end
         end
         FSPS_ST_RD: begin
            latch_d = sel_q ? fl_rdata_i[15:8] : fl_rdata_i[7:0];
            st_d = FSPS_ST_IDLE;
         end
         FSPS_ST_LONG: begin
            timer_d = timer_q - 17'h00001;
            if (timer_q <= 17'h00001) begin
               st_d = FSPS_ST_IDLE;
               launch_d = 1'b0;
               abort_d = 1'b0;
               done_d = 1'b1;
               prog_end = fl_prog_q;
               if (fl_erase_q) erase_d = 1'b0;
               fl_erase_d = 1'b0;
               fl_prog_d = 1'b0;
            end
         end
         default: st_d = FSPS_ST_IDLE;
      endcase
      stall_d = (st_d == FSPS_ST_LONG);
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_q <= FSPS_ST_IDLE;
         unl_q <= FSPS_UNL_NONE;
         ptr_q <= 22'h000000;
         latch_q <= 8'h00;
         pgm_q <= 1'b0;
         cfg_q <= 1'b0;
         erase_q <= 1'b0;
         // Reads set after any reset, so a reset that cut a cycle short shows
         abort_q <= 1'b1;
         permit_q <= 1'b0;
         launch_q <= 1'b0;
         done_q <= 1'b0;
         sel_q <= 1'b0;
         stall_q <= 1'b0;
         timer_q <= 17'h00000;
         prdata_q <= 32'h00000000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         fl_rd_q <= 1'b0;
         fl_addr_q <= 21'h000000;
         fl_erase_q <= 1'b0;
         fl_prog_q <= 1'b0;
         fl_row_q <= 16'h0000;
         fl_half_q <= 1'b0;
      end else begin
         st_q <= st_d;
         unl_q <= unl_d;
         ptr_q <= ptr_d;
         latch_q <= latch_d;
         pgm_q <= pgm_d;
         cfg_q <= cfg_d;
         erase_q <= erase_d;
         abort_q <= abort_d;
         permit_q <= permit_d;
         launch_q <= launch_d;
         done_q <= done_d;
         sel_q <= sel_d;
         stall_q <= stall_d;
         timer_q <= timer_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         fl_rd_q <= fl_rd_d;
         fl_addr_q <= fl_addr_d;
         fl_erase_q <= fl_erase_d;
         fl_prog_q <= fl_prog_d;
         fl_row_q <= fl_row_d;
         fl_half_q <= fl_half_d;
      end
   end
   // ****************************************
   // Holding registers
   // ****************************************
   for (genvar gi = 0; gi < `FSPS_HOLD_NUM; gi++) begin : g_hold
      always_comb begin
         hold_d[gi] = hold_q[gi];
         if (prog_end) hold_d[gi] = `FSPS_HOLD_RST;
         else if (tw_go && tw_idx == 5'(gi)) hold_d[gi] = latch_q;
      end
      always_ff @(posedge clk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            hold_q[gi] <= `FSPS_HOLD_RST;
         end else begin
            hold_q[gi] <= hold_d[gi];
         end
      end
      // Macro ANDs this into the array, so FFh lanes keep their byte
      assign fl_wdata_o[gi*8 +: 8] = hold_q[gi];
   end
   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
   assign cpu_stall_o = stall_q;
   assign fl_rd_o = fl_rd_q;
   assign fl_addr_o = fl_addr_q;
   assign fl_erase_o = fl_erase_q;
   assign fl_prog_o = fl_prog_q;
   assign fl_row_o = fl_row_q;
   assign fl_half_o = fl_half_q;
   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   launch_start_a: assert property (
      launch_ok |=> cpu_stall_o && timer_q == LONG_CYCLES && launch_q)
      else $error("Accepted launch did not start a timed cycle");
   no_unlock_a: assert property (
      bus_wr && paddr_i == `FSPS_OFS_CTRL && pwdata_i[`FSPS_CTRL_LAUNCH] && unl_q != FSPS_UNL_OPEN
      |=> !cpu_stall_o && abort_q)
      else $error("Launch without unlock started a cycle");
   timer_hold_a: assert property (
      cpu_stall_o && timer_q > 17'h00001 |=> cpu_stall_o && timer_q == $past(timer_q) - 17'h00001)
      else $error("Long cycle ended before timer expiry");
   stall_end_a: assert property (
      $fell(cpu_stall_o) |-> done_q && !launch_q && !abort_q && !pready_o)
      else $error("Cycle end did not clear launch or raise done");
   erase_row_a: assert property (
      fl_erase_o |-> fl_row_o == ptr_q[21:6] && !fl_prog_o)
      else $error("Erase row not taken from pointer bits 21:6");
   erase_clr_a: assert property (
      $fell(fl_erase_o) |-> !erase_q && !cpu_stall_o)
      else $error("Row-erase select not cleared after erase");
   hold_reset_a: assert property (
      $fell(fl_prog_o) |-> fl_wdata_o == {256{1'b1}})
      else $error("Holding registers not FFh after programming");
   byte_sel_a: assert property (
      st_q == FSPS_ST_RD |=> latch_q == ($past(sel_q) ? $past(fl_rdata_i[15:8]) : $past(fl_rdata_i[7:0])))
      else $error("Wrong byte of flash word latched");
   tw_hold_a: assert property (
      tw_go |=> !cpu_stall_o && hold_q[$past(tw_idx)] == $past(latch_q))
      else $error("Table write did not load holding register");
   post_inc_a: assert property (
      bus_wr && paddr_i == `FSPS_OFS_CMD && pwdata_i[1:0] == `FSPS_VAR_POSTINC
      |=> ptr_q[20:0] == $past(ptr_q[20:0]) + 21'h000001 && ptr_q[21] == $past(ptr_q[21]))
      else $error("Post-increment pointer wrong");

   erase_run_c: cover property ($rose(fl_erase_o));
   prog_run_c: cover property ($rose(fl_prog_o));
   table_read_c: cover property (st_q == FSPS_ST_RD);
   refused_c: cover property (bus_wr && paddr_i == `FSPS_OFS_CTRL && pwdata_i[`FSPS_CTRL_LAUNCH] && !launch_ok);
endmodule : fsps_top

// [shared/fsps_defs.svh]
// Constants of the flash self-program sequencer: register map, field positions, timing.
// Assumes inclusion by bare name from the design and bench files.
`ifndef FSPS_DEFS_SVH
`define FSPS_DEFS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define FSPS_OFS_CTRL 8'h00
`define FSPS_OFS_UNLOCK 8'h04
`define FSPS_OFS_PTR 8'h08
`define FSPS_OFS_LATCH 8'h0C
`define FSPS_OFS_CMD 8'h10
`define FSPS_OFS_STATUS 8'h14
// ****************************************
// Field positions
// ****************************************
`define FSPS_CTRL_PGM 7
`define FSPS_CTRL_CFG 6
`define FSPS_CTRL_ERASE 4
`define FSPS_CTRL_ABORT 3
`define FSPS_CTRL_PERMIT 2
`define FSPS_CTRL_LAUNCH 1
`define FSPS_CMD_WRITE 2
`define FSPS_STAT_DONE 0
`define FSPS_STAT_OPEN 1
`define FSPS_VAR_NONE 2'h0
`define FSPS_VAR_POSTINC 2'h1
`define FSPS_VAR_POSTDEC 2'h2
`define FSPS_VAR_PREINC 2'h3
// ****************************************
// Values and timing
// ****************************************
`define FSPS_KEY_FIRST 8'h55
`define FSPS_KEY_SECOND 8'hAA
`define FSPS_HOLD_RST 8'hFF
`define FSPS_HOLD_NUM 32
`define FSPS_CLK_NS 20
`define FSPS_LONG_NS 2000000
`define FSPS_LONG_CYC (`FSPS_LONG_NS / `FSPS_CLK_NS)
`endif

// [shared/fsps_pkg.sv]
// Types of the flash self-program sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package fsps_pkg;
   typedef enum logic [1:0] {FSPS_ST_IDLE, FSPS_ST_RD, FSPS_ST_LONG} fsps_state_t;
   typedef enum logic [1:0] {FSPS_UNL_NONE, FSPS_UNL_GOT1, FSPS_UNL_OPEN} fsps_unl_t;
endpackage : fsps_pkg

// [verif/fsps_flash_model.sv]
// Behavioural flash array seen through the sequencer's read port.
// Assumes the sequencer latches the word at the edge that ends its one-cycle read strobe.
`timescale 1ns/100ps
module fsps_flash_model (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic rd_i,
   input wire logic [20:0] addr_i,
   output logic [15:0] rdata_o
);
   // ****************************************
   // Read port
   // ****************************************
   // Word content is a function of its address, so the bench can predict every byte.
   // Outside a read answer the bus toggles, so a stale sample can never pass as valid.
   // The word answers while the strobe stands, since the sequencer takes it at the strobe's closing edge.
   logic [15:0] idle_q;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         idle_q <= 16'h0000;
      end else begin
         idle_q <= ~idle_q;
      end
   end
   assign rdata_o = rd_i ? {~addr_i[7:0], addr_i[7:0]} : idle_q;
endmodule : fsps_flash_model

// [verif/fsps_top_test.sv]
// Self-checking bench of the flash self-program sequencer, driven as an APB master.
// Assumes the flash model beside it and a shortened long-cycle count.
`timescale 1ns/100ps
`include "fsps_defs.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin fails++; \
   $display("unexpected at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module fsps_top_test;
   import fsps_pkg::*;
   // ****************************************
   // Signals
   // ****************************************
   // Short long-cycle count keeps the run brief; the wait bound LIMIT is a fixed 200, ten times it
   localparam int LONG = 20;
   localparam int LIMIT = 200;
   int fails = 0;
   int check_count = 0;
   int rd_pulses = 0;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, stall, fl_rd, fl_erase, fl_prog, fl_half;
   logic [20:0] fl_addr;
   logic [15:0] fl_rdata, fl_row;
   logic [255:0] fl_wdata;
   always #10 clk_i = ~clk_i;
   fsps_top #(.LONG_CYCLES(17'(LONG))) i_fsps_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .cpu_stall_o(stall), .fl_rd_o(fl_rd), .fl_addr_o(fl_addr),
      .fl_rdata_i(fl_rdata), .fl_erase_o(fl_erase), .fl_prog_o(fl_prog), .fl_row_o(fl_row),
      .fl_half_o(fl_half), .fl_wdata_o(fl_wdata));
   fsps_flash_model i_fsps_flash_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .rd_i(fl_rd), .addr_i(fl_addr),
      .rdata_o(fl_rdata));
   // Counts flash read strobes, sampled mid-cycle where they are settled
   always @(negedge clk_i) begin
      if (fl_rd === 1'b1) begin
         rd_pulses++;
      end
   end
   // ****************************************
   // Bus tasks
   // ****************************************
   task automatic finish_test();
      if (fails == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test
   // Entered right after a rising edge; pready is sampled at rising edges, as the slave sees it
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready !== 1'b1 && n < LIMIT);
      if (pready !== 1'b1) begin
         fails++;
         finish_test();
      end else begin
         r = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         // One idle edge, so a following call never assigns psel twice in one time step
         @(posedge clk_i);
      end
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      `CHK(e, 1'b0)
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      `CHK(r, x)
   endtask : rd_chk
   task automatic unlock();
      wr(`FSPS_OFS_STATUS, 32'h1);
      wr(`FSPS_OFS_UNLOCK, 32'h55);
      wr(`FSPS_OFS_UNLOCK, 32'hAA);
      rd_chk(`FSPS_OFS_STATUS, 32'h2);
   endtask : unlock
   // Checks one stalling cycle from the launch edge to its end
   task automatic long_run(input logic erase, input logic [15:0] row, input logic half);
      int n;
      // The launch write's closing idle cycle is already the stall's first
      n = 1;
      @(negedge clk_i);
      `CHK(stall, 1'b1)
      `CHK(fl_erase, erase)
      `CHK(fl_prog, ~erase)
      `CHK(fl_row, row)
      if (!erase) `CHK(fl_half, half)
      while (stall === 1'b1 && n < LIMIT) begin
         @(negedge clk_i);
         n++;
      end
      `CHK(n, LONG)
      `CHK(fl_erase | fl_prog, 1'b0)
      @(posedge clk_i);
      rd_chk(`FSPS_OFS_STATUS, 32'h1);
      rd_chk(`FSPS_OFS_CTRL, 32'h84);
   endtask : long_run
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_regs();
      logic [31:0] r;
      logic e;
      rd_chk(`FSPS_OFS_CTRL, 32'h08);
      apb(1'b0, 8'h18, 32'h0, r, e);
      `CHK({e, r}, 33'h100000000)
      apb(1'b1, 8'h1C, 32'h5, r, e);
      `CHK(e, 1'b1)
   endtask : t_regs
   // All four pointer variants in turn, starting from an odd byte address
   task automatic t_read();
      logic [21:0] p, q, a;
      p = 22'h000101;
      wr(`FSPS_OFS_PTR, {10'h0, p});
      for (int v = 0; v < 4; v++) begin
         a = (v == 3) ? p + 22'h1 : p;
         q = (v == 1 || v == 3) ? p + 22'h1 : (v == 2) ? p - 22'h1 : p;
         wr(`FSPS_OFS_CMD, 32'(v));
         `CHK(fl_addr, a[21:1])
         rd_chk(`FSPS_OFS_LATCH, {24'h0, a[0] ? ~a[8:1] : a[8:1]});
         rd_chk(`FSPS_OFS_PTR, {10'h0, q});
         p = q;
      end
      `CHK(rd_pulses, 4)
   endtask : t_read
   // One staged byte, then a block program; pointer bit 5 picks the upper half
   task automatic t_prog();
      wr(`FSPS_OFS_PTR, 32'h25);
      wr(`FSPS_OFS_LATCH, 32'h3C);
      wr(`FSPS_OFS_CMD, 32'h5);
      `CHK(stall, 1'b0)
      `CHK(fl_wdata, {{208{1'b1}}, 8'h3C, {40{1'b1}}})
      rd_chk(`FSPS_OFS_PTR, 32'h26);
      unlock();
      wr(`FSPS_OFS_CTRL, 32'h86);
      long_run(1'b0, 16'h0000, 1'b1);
      `CHK(fl_wdata, {256{1'b1}})
   endtask : t_prog
   task automatic bad(input logic [7:0] k2, input logic [7:0] c);
      wr(`FSPS_OFS_STATUS, 32'h1);
      wr(`FSPS_OFS_UNLOCK, 32'h55);
      wr(`FSPS_OFS_UNLOCK, {24'h0, k2});
      wr(`FSPS_OFS_CTRL, {24'h0, c});
      @(negedge clk_i);
      `CHK(stall | fl_erase | fl_prog, 1'b0)
      @(posedge clk_i);
      rd_chk(`FSPS_OFS_CTRL, {24'h0, (c & 8'hFD) | 8'h08});
      rd_chk(`FSPS_OFS_STATUS, 32'h0);
   endtask : bad
   task automatic t_erase();
      logic [21:0] p;
      p = 22'h2ABCDF;
      wr(`FSPS_OFS_PTR, {10'h0, p});
      unlock();
      wr(`FSPS_OFS_CTRL, 32'h96);
      long_run(1'b1, p[21:6], 1'b0);
   endtask : t_erase
   // A reset that cuts an erase short ends it and leaves the abort flag set
   task automatic t_cut();
      wr(`FSPS_OFS_PTR, 32'h40);
      unlock();
      wr(`FSPS_OFS_CTRL, 32'h96);
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      `CHK(stall | fl_erase, 1'b0)
      rd_chk(`FSPS_OFS_CTRL, 32'h08);
      rd_chk(`FSPS_OFS_STATUS, 32'h0);
   endtask : t_cut
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (12) @(posedge clk_i);
      `CHK(fl_wdata, {256{1'b1}})
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      t_regs();
      t_read();
      t_prog();
      bad(8'h12, 8'h86);
      bad(8'hAA, 8'hC6);
      bad(8'hAA, 8'h82);
      t_erase();
      t_cut();
      finish_test();
   end
endmodule : fsps_top_test
